// ### hw/asc_top.sv
// A/D conversion sequencing control with AHB-Lite register slave
// Functional notes
// - 10-bit resolution stores result in bits 9..0, 8-bit in bits 7..0.
// - With sample-hold on, a pin conversion takes 28 or 33 cycles.
// - Sampling window lasts 2 cycles, or 3 with sample-hold.
// - Trigger is software start, falling external pin edge, or motor-timer request.
// - Hardware triggers start conversion only while the start bit is set.
// - A hardware trigger during conversion aborts and restarts from the beginning.
// - DMA mode writes all results to register zero and requests a transfer.
// - Extended select: none, pin A input, pin B input, op-amp loop.
// - One-shot/repeat: pin A to result 0, pin B to result 1; DMA all 0.
// - Op-amp mode drives the channel on pin A, converts pin B into channel slot.
// - Repeat modes with DMA raise a request after every conversion.
// - Halting by clearing start may leave results undefined.
// - Halting a single sweep may raise a request; software masks first.
// - Software-started multiport single sweep clears start when the sweep ends.
`timescale 1ns/1ps
module asc_top
  import asc_pkg::*;
(
  input wire logic clk, // Conversion clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  output logic [31:0] hrdata, // AHB read data
  input wire logic ext_trigger_pin, // External trigger pin, asynchronous
  input wire logic hw_trigger, // Motor-timer request pulse, same clock
  input wire logic [9:0] conv_code, // Code from the converter core
  output logic [2:0] mux_ch, // Selected analog channel
  output logic conv_pin_a, // Convert extended pin A
  output logic conv_pin_b, // Convert extended pin B
  output logic opamp_drive, // Drive selected channel out on pin A
  output logic ref_connect_out, // Reference ladder connected
  output logic res10_out, // 10-bit resolution to the core
  output logic sampling_out, // Sampling window to the core
  output logic dma_req, // DMA transfer request pulse
  output logic irq_req // Interrupt request pulse
);
  asc_tmr_if tif ();

  asc_conv_timer u_tmr (
    .clk(clk),
    .arst_n(arst_n),
    .tif(tif.tmr)
  );

  // Bus group
  logic [7:0] a_addr;
  logic [7:0] next_a_addr;
  logic a_hit;
  logic next_a_hit;
  logic wr_pend;
  logic next_wr_pend;
  logic rd_pend;
  logic next_rd_pend;
  logic next_hreadyout;
  logic [31:0] next_hrdata;
  logic take;

  // Control group
  asc_cfg_t cfg;
  asc_cfg_t next_cfg;
  asc_state_t st;
  asc_state_t next_st;
  logic [3:0] idx;
  logic [3:0] next_idx;
  logic go;
  logic next_go;
  logic pend;
  logic next_pend;
  logic [9:0] results [8];
  logic [9:0] next_results [8];
  logic next_dma_req;
  logic next_irq_req;
  logic [2:0] next_mux_ch;
  logic next_conv_pin_a;
  logic next_conv_pin_b;
  logic next_opamp_drive;

  // Decode helpers
  logic res_wr;
  logic set_pend;
  logic clr_pend;
  logic trig_evt;
  logic is_sweep;
  logic last;
  logic [4:0] sweep_len;
  logic [2:0] cur_ch;
  logic [2:0] widx;
  logic [9:0] wval;

  // External pin synchroniser and debounced level
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;
  logic ext_lvl;
  logic ext_fall;

  assign tif.go = go;
  assign tif.sh_en = cfg.sh_en;
  assign tif.res10 = cfg.res_sel;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_s1 <= RST_HIGH;
      ext_s2 <= RST_HIGH;
      ext_s3 <= RST_HIGH;
      ext_lvl <= RST_HIGH;
    end else begin
      ext_s1 <= ext_trigger_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      ext_lvl <= (ext_s2 == ext_s3) ? ext_s3 : ext_lvl;
    end
  end

  // A high-to-low change counts only once two stages agree, filtering one-cycle glitches
  assign ext_fall = ext_lvl && (ext_s2 == ext_s3) && !ext_s3;
  assign trig_evt = cfg.trig_src && (cfg.hw_trig_sel ? hw_trigger : ext_fall);

  assign take = hsel && htrans[1] && hready;
  assign is_sweep = cfg.mode >= MODE_SINGLE_SWEEP;
  assign sweep_len = cfg.multiport_sweep_enable ? MP_SWEEP_LEN : {2'h0, cfg.sweep_sel, 1'b0} + 5'h02;
  assign last = ({1'b0, idx} == sweep_len - 5'h01);
  assign cur_ch = is_sweep ? idx[2:0] : cfg.pin_sel;
  assign widx = res_index(cfg.dma_en, cfg.mode, cfg.ext_sel, cur_ch);
  assign wval = cfg.res_sel ? conv_code : {2'h0, conv_code[7:0]};

  always_comb begin
    next_a_addr = a_addr;
    next_a_hit = a_hit;
    next_wr_pend = take && hwrite;
    next_rd_pend = take && !hwrite;
    // Reads take one wait state so that read data leaves a flip-flop
    next_hreadyout = !(take && !hwrite);
    next_hrdata = hrdata;
    if (take) begin
      next_a_addr = haddr[7:0];
      next_a_hit = (haddr[31:8] == 24'h000000);
    end
    if (rd_pend) begin
      next_hrdata = 32'h00000000;
      if (a_hit) begin
        case (a_addr)
          OFS_CTRL_A: begin
            next_hrdata[A_START] = cfg.conv_start;
            next_hrdata[A_TRG] = cfg.trig_src;
            next_hrdata[A_MODE +: 3] = cfg.mode;
            next_hrdata[A_PIN +: 3] = cfg.pin_sel;
          end
          OFS_CTRL_B: begin
            next_hrdata[B_RES] = cfg.res_sel;
            next_hrdata[B_REF] = cfg.ref_conn;
            next_hrdata[B_EXT +: 2] = cfg.ext_sel;
            next_hrdata[B_SWP +: 2] = cfg.sweep_sel;
          end
          OFS_CTRL_C: begin
            next_hrdata[C_SMP] = cfg.sh_en;
            next_hrdata[C_HW_TRIGGER_SELECT] = cfg.hw_trig_sel;
            next_hrdata[C_GRP +: 2] = cfg.grp_sel;
          end
          OFS_CTRL_D: begin
            next_hrdata[D_DUS] = cfg.dma_en;
            next_hrdata[D_MSS] = cfg.multiport_sweep_enable;
          end
          OFS_INT: begin
            next_hrdata[I_PEND] = pend;
            next_hrdata[I_BUSY] = (st == ST_CONV);
          end
          default: begin
            if (a_addr >= OFS_RES0 && a_addr < OFS_RES_END) begin
              next_hrdata[9:0] = results[a_addr[4:2]];
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      a_addr <= 8'h00;
      a_hit <= RST_OFF;
      wr_pend <= RST_OFF;
      rd_pend <= RST_OFF;
      hreadyout <= RST_HIGH;
      hresp <= RST_OFF;
      hrdata <= 32'h00000000;
    end else begin
      a_addr <= next_a_addr;
      a_hit <= next_a_hit;
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      hreadyout <= next_hreadyout;
      hresp <= RST_OFF;
      hrdata <= next_hrdata;
    end
  end

  always_comb begin
    next_cfg = cfg;
    next_st = st;
    next_idx = idx;
    next_go = 1'b0;
    next_results = results;
    res_wr = 1'b0;
    set_pend = 1'b0;
    clr_pend = 1'b0;
    case (st)
      ST_IDLE: begin
        if (cfg.conv_start) begin
          if (cfg.trig_src) begin
            next_st = ST_WAIT;
          end else begin
            next_st = ST_CONV;
            next_go = 1'b1;
            next_idx = 4'h0;
          end
        end
      end
      ST_WAIT: begin
        if (!cfg.conv_start) begin
          next_st = ST_IDLE;
        end else if (trig_evt) begin
          next_st = ST_CONV;
          next_go = 1'b1;
          next_idx = 4'h0;
        end
      end
      ST_CONV: begin
        // Halting leaves the partial result untouched and simply drops the sequence
        if (!cfg.conv_start) begin
          next_st = ST_IDLE;
        end else if (trig_evt) begin
          next_go = 1'b1;
          next_idx = 4'h0;
        end else if (tif.done) begin
          res_wr = 1'b1;
          next_results[widx] = wval;
          set_pend = cfg.dma_en || (cfg.mode == MODE_ONE_SHOT) || (cfg.mode == MODE_SINGLE_SWEEP && last);
          if (cfg.mode == MODE_ONE_SHOT || (cfg.mode == MODE_SINGLE_SWEEP && last)) begin
            next_st = cfg.trig_src ? ST_WAIT : ST_IDLE;
            if (!cfg.trig_src) begin
              next_cfg.conv_start = 1'b0;
            end
          end else begin
            next_go = 1'b1;
            if (is_sweep) begin
              next_idx = last ? 4'h0 : idx + 4'h1;
            end
          end
        end
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
    // A software write in the same cycle overrides the automatic stop
    if (wr_pend && a_hit) begin
      case (a_addr)
        OFS_CTRL_A: begin
          next_cfg.conv_start = hwdata[A_START];
          next_cfg.trig_src = hwdata[A_TRG];
          next_cfg.mode = hwdata[A_MODE +: 3];
          next_cfg.pin_sel = hwdata[A_PIN +: 3];
        end
        OFS_CTRL_B: begin
          next_cfg.res_sel = hwdata[B_RES];
          next_cfg.ref_conn = hwdata[B_REF];
          next_cfg.ext_sel = hwdata[B_EXT +: 2];
          next_cfg.sweep_sel = hwdata[B_SWP +: 2];
        end
        OFS_CTRL_C: begin
          next_cfg.sh_en = hwdata[C_SMP];
          next_cfg.hw_trig_sel = hwdata[C_HW_TRIGGER_SELECT];
          next_cfg.grp_sel = hwdata[C_GRP +: 2];
        end
        OFS_CTRL_D: begin
          next_cfg.dma_en = hwdata[D_DUS];
          next_cfg.multiport_sweep_enable = hwdata[D_MSS];
        end
        OFS_INT: begin
          clr_pend = !hwdata[I_PEND];
        end
        default: begin
        end
      endcase
    end
    next_pend = (pend && !clr_pend) || set_pend;
    next_dma_req = res_wr && cfg.dma_en;
    next_irq_req = set_pend;
    next_mux_ch = cur_ch;
    next_conv_pin_a = !is_sweep && (cfg.ext_sel == EXT_A);
    next_conv_pin_b = !is_sweep && (cfg.ext_sel == EXT_B || cfg.ext_sel == EXT_OPAMP);
    next_opamp_drive = !is_sweep && (cfg.ext_sel == EXT_OPAMP);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= CFG_RST;
      st <= ST_IDLE;
      idx <= 4'h0;
      go <= RST_OFF;
      pend <= RST_OFF;
      for (int i = 0; i < 8; i++) begin
        results[i] <= RST_RESULT;
      end
      dma_req <= RST_OFF;
      irq_req <= RST_OFF;
      mux_ch <= 3'h0;
      conv_pin_a <= RST_OFF;
      conv_pin_b <= RST_OFF;
      opamp_drive <= RST_OFF;
      ref_connect_out <= RST_OFF;
      res10_out <= RST_OFF;
      sampling_out <= RST_OFF;
    end else begin
      cfg <= next_cfg;
      st <= next_st;
      idx <= next_idx;
      go <= next_go;
      pend <= next_pend;
      results <= next_results;
      dma_req <= next_dma_req;
      irq_req <= next_irq_req;
      mux_ch <= next_mux_ch;
      conv_pin_a <= next_conv_pin_a;
      conv_pin_b <= next_conv_pin_b;
      opamp_drive <= next_opamp_drive;
      ref_connect_out <= cfg.ref_conn;
      res10_out <= cfg.res_sel;
      sampling_out <= tif.sampling;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_res_store: assert property (res_wr |=> results[$past(widx)] == $past(wval))
    else $error("result not stored in its register");
  a_res_clean8: assert property ((res_wr && !cfg.res_sel) |=> results[$past(widx)][9:8] == 2'h0)
    else $error("upper result bits not zero at 8-bit");
  a_dma_after_wr: assert property ((res_wr && cfg.dma_en) |=> dma_req ##1 !dma_req)
    else $error("DMA request not a pulse after result write");
  a_dma_to_zero: assert property ((res_wr && cfg.dma_en) |-> widx == 3'h0)
    else $error("DMA result not routed to register zero");
  a_trig_ignored: assert property (!cfg.conv_start |=> !go)
    else $error("conversion started with start bit clear");
  a_abort_restart: assert property ((st == ST_CONV && cfg.conv_start && trig_evt) |=> go && idx == 4'h0)
    else $error("trigger during conversion did not restart");
  a_opamp_route: assert property ((cfg.ext_sel == EXT_OPAMP && !is_sweep) |=> opamp_drive && conv_pin_b && !conv_pin_a)
    else $error("op-amp routing wrong");
  a_sweep_stop: assert property ((st == ST_CONV && tif.done && cfg.conv_start && !trig_evt && !wr_pend &&
                                  cfg.mode == MODE_SINGLE_SWEEP && last && !cfg.trig_src) |=> !cfg.conv_start && st == ST_IDLE)
    else $error("single sweep did not clear start");
  a_dma_irq: assert property ((res_wr && cfg.dma_en) |=> pend && irq_req)
    else $error("no request after DMA-mode conversion");

endmodule : asc_top

// ### hw/asc_pkg.sv
// Shared constants, field positions and types for the A/D sequencing control block
package asc_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CTRL_C = 8'h08;
  localparam logic [7:0] OFS_CTRL_D = 8'h0C;
  localparam logic [7:0] OFS_INT = 8'h10;
  localparam logic [7:0] OFS_RES0 = 8'h20;
  localparam logic [7:0] OFS_RES_END = 8'h40;

  // Field positions
  localparam int A_START = 0;
  localparam int A_TRG = 1;
  localparam int A_MODE = 2;
  localparam int A_PIN = 5;
  localparam int B_RES = 0;
  localparam int B_REF = 1;
  localparam int B_EXT = 2;
  localparam int B_SWP = 4;
  localparam int C_SMP = 0;
  localparam int C_HW_TRIGGER_SELECT = 1;
  localparam int C_GRP = 2;
  localparam int D_DUS = 0;
  localparam int D_MSS = 1;
  localparam int I_PEND = 0;
  localparam int I_BUSY = 1;

  // Conversion timing in conversion-clock cycles
  localparam logic [5:0] CYC_SH_8 = 6'h1C;
  localparam logic [5:0] CYC_SH_10 = 6'h21;
  localparam logic [5:0] CYC_NS_8 = 6'h2F;
  localparam logic [5:0] CYC_NS_10 = 6'h39;
  localparam logic [5:0] SAMP_NS = 6'h02;
  localparam logic [5:0] SAMP_SH = 6'h03;

  // Operating modes
  localparam logic [2:0] MODE_ONE_SHOT = 3'h0;
  localparam logic [2:0] MODE_REPEAT = 3'h1;
  localparam logic [2:0] MODE_SINGLE_SWEEP = 3'h2;

  // Extended input pin usage
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_A = 2'h1;
  localparam logic [1:0] EXT_B = 2'h2;
  localparam logic [1:0] EXT_OPAMP = 2'h3;

  localparam logic [4:0] MP_SWEEP_LEN = 5'h10;
  localparam logic RST_OFF = 1'b0;
  localparam logic RST_HIGH = 1'b1;
  localparam logic [9:0] RST_RESULT = 10'h000;

  typedef struct packed {
    logic conv_start;
    logic trig_src;
    logic [2:0] mode;
    logic [2:0] pin_sel;
    logic res_sel;
    logic ref_conn;
    logic [1:0] ext_sel;
    logic [1:0] sweep_sel;
    logic sh_en;
    logic hw_trig_sel;
    logic [1:0] grp_sel;
    logic dma_en;
    logic multiport_sweep_enable;
  } asc_cfg_t;

  localparam asc_cfg_t CFG_RST = '0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b100
  } asc_state_t;

  // Result register that a finished conversion lands in
  function automatic logic [2:0] res_index(input logic dma, input logic [2:0] mode,
                                           input logic [1:0] ext, input logic [2:0] ch);
    logic [2:0] idx;
    idx = ch;
    if (dma) begin
      idx = 3'h0;
    end else if (mode == MODE_ONE_SHOT || mode == MODE_REPEAT) begin
      if (ext == EXT_A) begin
        idx = 3'h0;
      end else if (ext == EXT_B) begin
        idx = 3'h1;
      end
    end
    return idx;
  endfunction : res_index

endpackage : asc_pkg

// ### hw/asc_tmr_if.sv
// Handshake between the sequencer and the conversion timer
`timescale 1ns/1ps
interface asc_tmr_if;
  logic go;
  logic sh_en;
  logic res10;
  logic sampling;
  logic done;
  modport ctl (output go, output sh_en, output res10, input sampling, input done);
  modport tmr (input go, input sh_en, input res10, output sampling, output done);
endinterface : asc_tmr_if

// ### hw/asc_conv_timer.sv
// Per-pin conversion timer: sampling window and conversion length
`timescale 1ns/1ps
module asc_conv_timer
  import asc_pkg::*;
(
  input wire logic clk, // Conversion clock
  input wire logic arst_n, // Asynchronous reset
  asc_tmr_if.tmr tif // Sequencer handshake
);
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic busy;
  logic next_busy;
  logic [5:0] total;
  logic [5:0] samp;

  assign total = tif.sh_en ? (tif.res10 ? CYC_SH_10 : CYC_SH_8) : (tif.res10 ? CYC_NS_10 : CYC_NS_8);
  assign samp = tif.sh_en ? SAMP_SH : SAMP_NS;
  // A run overtaken by a new go must not report its stale end in the go cycle
  assign tif.done = busy && !tif.go && (cnt == total - 6'h01);
  assign tif.sampling = busy && (cnt < samp);

  always_comb begin
    next_cnt = cnt;
    next_busy = busy;
    // A new go restarts the count even mid-conversion, which is how aborts work
    if (tif.go) begin
      next_busy = 1'b1;
      next_cnt = 6'h00;
    end else if (busy) begin
      if (tif.done) begin
        next_busy = 1'b0;
      end else begin
        next_cnt = cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 6'h00;
      busy <= RST_OFF;
    end else begin
      cnt <= next_cnt;
      busy <= next_busy;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_len_sh_8: assert property ((tif.done && tif.sh_en && !tif.res10) |-> cnt == 6'h1B)
    else $error("8-bit sample-hold conversion length wrong");
  a_len_sh_10: assert property ((tif.done && tif.sh_en && tif.res10) |-> cnt == 6'h20)
    else $error("10-bit sample-hold conversion length wrong");
  a_samp_ns: assert property ((tif.go && !tif.sh_en) ##1 (!tif.go && tif.sampling) ##1
                              (!tif.go && tif.sampling) |=> !tif.sampling)
    else $error("sampling window without sample-hold not 2 cycles");
  a_samp_sh: assert property ((tif.go && tif.sh_en) |=> tif.sampling [*3])
    else $error("sampling window with sample-hold shorter than 3 cycles");

endmodule : asc_conv_timer

// ### testbench/asc_core_model.sv
// Behavioural converter core that hands back a code for whatever input is selected
`timescale 1ns/1ps
module asc_core_model (
  input wire logic clk, // Conversion clock
  input wire logic [2:0] mux_ch, // Channel being converted
  input wire logic conv_pin_a, // Extended pin A selected
  input wire logic conv_pin_b, // Extended pin B selected
  input wire logic sampling_out, // Sampling window
  output logic [9:0] conv_code // Code handed back
);
  logic [9:0] held = 10'h000;
  // Extended pins give a code without the channel, so a wrong result slot shows up
  always @(posedge clk) begin
    if (sampling_out) begin
      held <= (conv_pin_a | conv_pin_b) ? {3'h5, conv_pin_b, conv_pin_a, 5'h00} : {7'h50, mux_ch};
    end
  end
  assign conv_code = held;
endmodule : asc_core_model

// ### testbench/testbench.sv
// Self-checking bench for the A/D sequencing control block
`timescale 1ns/1ps
module testbench
  import asc_pkg::*;
();
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic ext_trigger_pin = 1'b1;
  logic hw_trigger = 1'b0;
  logic hreadyout, hresp, conv_pin_a, conv_pin_b, opamp_drive, ref_connect_out, res10_out;
  logic sampling_out, dma_req, irq_req, op;
  logic [31:0] hrdata, r;
  logic [9:0] conv_code;
  logic [2:0] mux_ch;
  logic [1:0] pq;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  int dur, samp, cnt;

  always #4 clk = ~clk;

  asc_top u_asc_top (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ext_trigger_pin(ext_trigger_pin), .hw_trigger(hw_trigger),
    .conv_code(conv_code), .mux_ch(mux_ch), .conv_pin_a(conv_pin_a), .conv_pin_b(conv_pin_b),
    .opamp_drive(opamp_drive), .ref_connect_out(ref_connect_out), .res10_out(res10_out),
    .sampling_out(sampling_out), .dma_req(dma_req), .irq_req(irq_req));

  asc_core_model u_asc_core_model (.clk(clk), .mux_ch(mux_ch), .conv_pin_a(conv_pin_a),
    .conv_pin_b(conv_pin_b), .sampling_out(sampling_out), .conv_code(conv_code));

  task automatic final_report();
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Ready and read data are taken at the rising edge, before the slave's flops move on
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic pulse();
    @(posedge clk);
    hw_trigger <= 1'b1;
    @(posedge clk);
    hw_trigger <= 1'b0;
  endtask : pulse

  // Measures one conversion from the first sampling cycle to its request pulse
  task automatic conv();
    cnt = 0;
    while (sampling_out !== 1'b1 && cnt < 400) begin
      @(negedge clk);
      cnt++;
    end
    op = opamp_drive;
    dur = 0;
    samp = 0;
    while (irq_req !== 1'b1 && dma_req !== 1'b1 && dur < 400) begin
      samp += int'(sampling_out === 1'b1);
      @(negedge clk);
      dur++;
    end
    pq = {dma_req, irq_req};
  endtask : conv

  function automatic int nlen(input logic sh, input logic res);
    if (sh) begin
      return res ? 33 : 28;
    end
    return res ? int'(CYC_NS_10) : int'(CYC_NS_8);
  endfunction : nlen

  function automatic logic [31:0] code(input logic pa, input logic pb, input logic [2:0] ch, input logic res);
    logic [9:0] c;
    c = (pa | pb) ? {3'h5, pb, pa, 5'h00} : {7'h50, ch};
    return res ? {22'h0, c} : {24'h0, c[7:0]};
  endfunction : code

  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFS_CTRL_A);
    chk(r, 32'h0);
    wr(8'hF0, 32'hFFFFFFFF);
    rd(8'hF0);
    chk(r, 32'h0);
    chk(hresp, 1'b0);
    wr(OFS_CTRL_B, 32'h2);
    repeat (125) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL_B, {30'h0, 1'b1, i[0]});
      wr(OFS_CTRL_C, {31'h0, i[1]});
      wr(OFS_INT, 32'h0);
      wr(OFS_CTRL_A, {24'h0, 3'(i + 2), 5'h01});
      chk({ref_connect_out, res10_out}, {30'h0, 1'b1, i[0]});
      conv();
      chk(dur, nlen(i[1], i[0]) - 1);
      chk(samp, i[1] ? 3 : 2);
      rd(OFS_INT);
      chk(r & 32'h1, 32'h1);
      rd(OFS_RES0 + 8'(4 * (i + 2)));
      chk(r, code(1'b0, 1'b0, 3'(i + 2), i[0]));
    end
    for (int e = 1; e < 4; e++) begin
      wr(OFS_CTRL_B, {28'h0, 2'(e), 2'h3});
      wr(OFS_CTRL_A, {24'h0, 3'h6, 5'h01});
      conv();
      chk(op, e == 3);
      rd(OFS_RES0 + (e == 1 ? 8'h0 : e == 2 ? 8'h4 : 8'h18));
      chk(r, code(e == 1, e > 1, 3'h6, 1'b1));
    end
    wr(OFS_CTRL_B, 32'h3);
    wr(OFS_CTRL_D, 32'h1);
    wr(OFS_CTRL_A, {24'h0, 3'h4, 5'h05});
    repeat (2) begin
      conv();
      chk(pq, 2'h3);
      chk(dur, 32);
    end
    rd(OFS_RES0);
    chk(r, code(1'b0, 1'b0, 3'h4, 1'b1));
    wr(OFS_CTRL_A, 32'h0);
    wr(OFS_CTRL_D, 32'h0);
    wr(OFS_CTRL_C, 32'h3);
    wr(OFS_CTRL_B, 32'h2);
    wr(OFS_INT, 32'h0);
    wr(OFS_CTRL_A, {24'h0, 3'h1, 5'h02});
    pulse();
    repeat (60) @(posedge clk);
    rd(OFS_INT);
    chk(r & 32'h1, 32'h0);
    wr(OFS_CTRL_A, {24'h0, 3'h1, 5'h03});
    pulse();
    repeat (10) @(posedge clk);
    pulse();
    conv();
    chk(dur, 27);
    wr(OFS_CTRL_A, 32'h0);
    wr(OFS_CTRL_C, 32'h1);
    wr(OFS_CTRL_A, {24'h0, 3'h2, 5'h03});
    @(posedge clk);
    ext_trigger_pin <= 1'b0;
    conv();
    chk(dur, 27);
    rd(OFS_RES0 + 8'h8);
    chk(r, code(1'b0, 1'b0, 3'h2, 1'b0));
    @(posedge clk);
    ext_trigger_pin <= 1'b1;
    wr(OFS_CTRL_A, 32'h0);
    wr(OFS_CTRL_D, 32'h3);
    wr(OFS_CTRL_A, 32'h09);
    cnt = 0;
    repeat (700) begin
      @(negedge clk);
      cnt += int'(dma_req === 1'b1);
    end
    chk(cnt, 16);
    rd(OFS_CTRL_A);
    chk(r & 32'h1, 32'h0);
    rd(OFS_RES0);
    chk(r, code(1'b0, 1'b0, 3'h7, 1'b0));
    wr(OFS_CTRL_D, 32'h0);
    wr(OFS_CTRL_B, 32'h3);
    wr(OFS_INT, 32'h0);
    wr(OFS_CTRL_A, 32'h0D);
    repeat (100) @(posedge clk);
    rd(OFS_RES0 + 8'h4);
    chk(r, code(1'b0, 1'b0, 3'h1, 1'b1));
    rd(OFS_INT);
    chk(r, 32'h2);
    wr(OFS_CTRL_A, 32'h0);
    final_report();
  end
endmodule : testbench
